// file: testbench.sv
// self-checking bench of the tag interrupt unit
`timescale 1ns/100ps
module testbench;
	import tiu_pkg::*;
	logic         mclk = 1'b0;
	logic         rst = 1'b1;
	tiu_events_t  events = '0;
	logic         buffer_mode = 1'b1;
	logic         cmd_set_default = 1'b0;
	logic         nv_load = 1'b0;
	tiu_reg_req_t reg_req;
	tiu_reg_rsp_t reg_rsp;
	logic         irq;
	int           fails = 0;
	int           check_count = 0;
	always #4 mclk = ~mclk;
	tiu_host_model host (.mclk(mclk), .reg_req(reg_req), .reg_rsp(reg_rsp));
	tiu_interrupt_unit uut (.mclk(mclk), .rst(rst), .events(events), .buffer_mode(buffer_mode),
		.cmd_set_default(cmd_set_default), .nv_load(nv_load), .nv_mask_defaults_low(8'hFE),
		.nv_mask_defaults_high(8'h7F), .reg_req(reg_req), .reg_rsp_ff(reg_rsp), .irq_ff(irq));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host.reg_read(a, d);
		chk(d, exp);
	endtask : rchk
	task automatic pulse_event(input logic [19:0] e);
		@(posedge mclk);
		events <= tiu_events_t'(e);
		@(posedge mclk);
		events <= '0;
	endtask : pulse_event
	task automatic pulse(input logic [1:0] c);
		@(posedge mclk);
		{cmd_set_default, nv_load} <= c;
		@(posedge mclk);
		{cmd_set_default, nv_load} <= 2'b00;
	endtask : pulse
	task automatic t_reset;
		rchk(8'h0A, 8'h00);
		rchk(8'h0B, 8'h00);
		rchk(8'h08, 8'hFF);
		host.reg_write(8'h0A, 8'hFF);
		rchk(8'h0A, 8'h00);
		rchk(8'h20, 8'h00);
	endtask : t_reset
	task automatic t_sources;
		logic [7:0] a;
		logic [7:0] e;
		pulse(2'b01);
		rchk(8'h08, 8'hFE);
		rchk(8'h09, 8'h7F);
		for (int k = 0; k < 20; k++) begin
			a = (k < 8) ? 8'h0B : 8'h0A;
			pulse_event(20'h00001 << k);
			#1;
			chk({7'h00, irq}, {7'h00, k == 7 || k == 8});
			e = 8'h01 << ((k < 8) ? k : (k > 14) ? 7 : k - 8);
			rchk(a, e);
			rchk(a, 8'h00);
		end
	endtask : t_sources
	task automatic t_mode;
		@(posedge mclk);
		buffer_mode <= 1'b0;
		pulse_event(20'h00480);
		rchk(8'h0A, 8'h00);
		rchk(8'h0B, 8'h00);
		@(posedge mclk);
		buffer_mode <= 1'b1;
	endtask : t_mode
	task automatic t_mask;
		host.reg_write(8'h08, 8'hFF);
		rchk(8'h08, 8'hFF);
		pulse_event(20'h00100);
		#1;
		chk({7'h00, irq}, 8'h00);
		rchk(8'h0A, 8'h01);
		// receive start is the only source left unmasked by the high defaults
		pulse_event(20'h00080);
		#1;
		chk({7'h00, irq}, 8'h01);
		host.reg_write(8'h09, 8'hFF);
		#1;
		chk({7'h00, irq}, 8'h00);
		rchk(8'h0B, 8'h80);
	endtask : t_mask
	task automatic t_setdef;
		pulse_event(20'h00100);
		pulse(2'b10);
		rchk(8'h0A, 8'h80);
		rchk(8'h08, 8'hFE);
	endtask : t_setdef
	task automatic give_verdict;
		$display("checks %0d errors %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	initial begin
		#20000;
		fails++;
		give_verdict;
	end
	initial begin
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		t_reset;
		t_sources;
		t_mode;
		t_mask;
		t_setdef;
		give_verdict;
	end
endmodule : testbench

// file: tiu_defs.svh
// register map, field positions, reset values of the tag interrupt unit
`ifndef TIU_DEFS_SVH
`define TIU_DEFS_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define TIU_ADDR_W          8
`define TIU_DATA_W          8
`define TIU_ADDR_MASK_LOW   8'h08
`define TIU_ADDR_MASK_HIGH  8'h09
`define TIU_ADDR_FLAGS_LOW  8'h0A
`define TIU_ADDR_FLAGS_HIGH 8'h0B

// ----------------------------------------
// reset values
// ----------------------------------------
`define TIU_FLAGS_RST       8'h00
`define TIU_MASK_RST        8'hFF
`define TIU_RDATA_UNMAPPED  8'h00

// ----------------------------------------
// low register bit positions
// ----------------------------------------
`define TIU_BIT_INIT        7
`define TIU_BIT_WAKEUP      6
`define TIU_BIT_SLEEP_REQ   5
`define TIU_BIT_RD_WRITE    4
`define TIU_BIT_RD_READ     3
`define TIU_BIT_RX_END      2
`define TIU_BIT_TX_END      1
`define TIU_BIT_FIELD_EXIT  0

// ----------------------------------------
// high register bit positions
// ----------------------------------------
`define TIU_BIT_RX_START    7
`define TIU_BIT_FRAMING     6
`define TIU_BIT_PARITY      5
`define TIU_BIT_CRC         4
`define TIU_BIT_BUF_FAULT   3
`define TIU_BIT_HOST_PROG   2
`define TIU_BIT_PROT_WRITE  1
`define TIU_BIT_ACCESS      0

`endif

// file: tiu_flag_reg.sv
// sticky flag register with clear and set-wins merge
`timescale 1ns/100ps
module tiu_flag_reg #(
	parameter int W = 8
) (
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic [W-1:0] set,
	input  wire logic         clr,
	output logic      [W-1:0] flags_ff,
	output logic      [W-1:0] nxt_flags
);
	import tiu_pkg::*;

	// ----------------------------------------
	// merge
	// ----------------------------------------
	// a set in the clearing cycle survives
	assign nxt_flags = (clr ? {W{1'b0}} : flags_ff) | set;

	always_ff @(posedge mclk) begin
		if (rst) flags_ff <= {W{1'b0}};
		else     flags_ff <= nxt_flags;
	end

endmodule : tiu_flag_reg

// file: tiu_host_model.sv
// host side register master of the tag interrupt unit
`timescale 1ns/100ps
module tiu_host_model (
	input  wire logic                  mclk,
	output tiu_pkg::tiu_reg_req_t      reg_req,
	input  wire tiu_pkg::tiu_reg_rsp_t reg_rsp
);
	import tiu_pkg::*;
	initial reg_req = '0;
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_req <= '{1'b0, 1'b1, a, d};
		@(posedge mclk);
		reg_req <= '0;
	endtask : reg_write
	// answer is sampled just after the edge that raised valid
	task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_req <= '{1'b1, 1'b0, a, 8'h00};
		@(posedge mclk);
		reg_req <= '0;
		#1;
		d = reg_rsp.valid ? reg_rsp.rdata : ~reg_rsp.rdata;
	endtask : reg_read
endmodule : tiu_host_model

// file: tiu_interrupt_unit.sv
// interrupt latch, mask and register port of the tag interrupt unit
`timescale 1ns/100ps
`include "tiu_defs.svh"
module tiu_interrupt_unit #(
	parameter int AW = `TIU_ADDR_W,
	parameter int DW = `TIU_DATA_W
) (
	input  wire logic                 mclk,
	input  wire logic                 rst,
	input  wire tiu_pkg::tiu_events_t events,
	input  wire logic                 buffer_mode,
	input  wire logic                 cmd_set_default,
	input  wire logic                 nv_load,
	input  wire logic [DW-1:0]        nv_mask_defaults_low,
	input  wire logic [DW-1:0]        nv_mask_defaults_high,
	input  wire tiu_pkg::tiu_reg_req_t reg_req,
	output tiu_pkg::tiu_reg_rsp_t     reg_rsp_ff,
	output logic                      irq_ff
);
	import tiu_pkg::*;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	function automatic logic addr_hit(input logic [AW-1:0] a, input logic [AW-1:0] ref_a);
		addr_hit = (a == ref_a);
	endfunction : addr_hit

	wire logic hit_mask_low;
	wire logic hit_mask_high;
	wire logic hit_flags_low;
	wire logic hit_flags_high;
	wire logic wr_mask_low;
	wire logic wr_mask_high;
	wire logic rd_flags_low;
	wire logic rd_flags_high;

	assign hit_mask_low   = addr_hit(reg_req.addr, `TIU_ADDR_MASK_LOW);
	assign hit_mask_high  = addr_hit(reg_req.addr, `TIU_ADDR_MASK_HIGH);
	assign hit_flags_low  = addr_hit(reg_req.addr, `TIU_ADDR_FLAGS_LOW);
	assign hit_flags_high = addr_hit(reg_req.addr, `TIU_ADDR_FLAGS_HIGH);

	// flag registers are read only, writes to them fall away
	assign wr_mask_low   = reg_req.wr_en & hit_mask_low;
	assign wr_mask_high  = reg_req.wr_en & hit_mask_high;
	assign rd_flags_low  = reg_req.rd_en & hit_flags_low;
	assign rd_flags_high = reg_req.rd_en & hit_flags_high;

	// ----------------------------------------
	// event collection, low register
	// ----------------------------------------
	logic [DW-1:0] set_low;
	logic [DW-1:0] set_high;
	wire  logic    init_cause;

	// set-default both clears and re-raises init, the set wins
	assign init_cause = events.power_up | events.field_on_powered | events.cmd_go_sleep
		| events.cmd_go_sense | events.cmd_sense_sleep | cmd_set_default;

	always_comb begin
		set_low                      = '0;
		set_low[`TIU_BIT_INIT]       = init_cause;
		set_low[`TIU_BIT_WAKEUP]     = events.selected_wakeup_event;
		set_low[`TIU_BIT_SLEEP_REQ]  = events.sleep_req;
		set_low[`TIU_BIT_RD_WRITE]   = events.reader_write_event;
		set_low[`TIU_BIT_RD_READ]    = events.reader_read_event;
		set_low[`TIU_BIT_RX_END]     = events.rx_end & buffer_mode;
		set_low[`TIU_BIT_TX_END]     = events.tx_end;
		set_low[`TIU_BIT_FIELD_EXIT] = events.field_exit;
	end

	// ----------------------------------------
	// event collection, high register
	// ----------------------------------------
	// error frames are still stored by the buffer logic; only the flag is raised here
	always_comb begin
		set_high                      = '0;
		set_high[`TIU_BIT_RX_START]   = events.rx_start & buffer_mode;
		set_high[`TIU_BIT_FRAMING]    = events.framing_err;
		set_high[`TIU_BIT_PARITY]     = events.parity_err;
		set_high[`TIU_BIT_CRC]        = events.crc_err;
		set_high[`TIU_BIT_BUF_FAULT]  = events.buffer_fault_event;
		set_high[`TIU_BIT_HOST_PROG]  = events.host_prog_done;
		set_high[`TIU_BIT_PROT_WRITE] = events.prot_write_err;
		set_high[`TIU_BIT_ACCESS]     = events.access_err;
	end

	// ----------------------------------------
	// flag registers
	// ----------------------------------------
	wire  logic          clr_low;
	wire  logic          clr_high;
	logic [DW-1:0]       flags_low_ff;
	logic [DW-1:0]       flags_high_ff;
	logic [DW-1:0]       nxt_flags_low;
	logic [DW-1:0]       nxt_flags_high;

	assign clr_low  = rd_flags_low  | cmd_set_default | events.power_up;
	assign clr_high = rd_flags_high | cmd_set_default | events.power_up;

	tiu_flag_reg #(
		.W         (DW)
	) u_flags_low (
		.mclk      (mclk),
		.rst       (rst),
		.set       (set_low),
		.clr       (clr_low),
		.flags_ff  (flags_low_ff),
		.nxt_flags (nxt_flags_low)
	);

	tiu_flag_reg #(
		.W         (DW)
	) u_flags_high (
		.mclk      (mclk),
		.rst       (rst),
		.set       (set_high),
		.clr       (clr_high),
		.flags_ff  (flags_high_ff),
		.nxt_flags (nxt_flags_high)
	);

	// ----------------------------------------
	// mask registers
	// ----------------------------------------
	// all masked until configuration arrives, so no spurious line activity at start
	logic [DW-1:0] mask_low_ff;
	logic [DW-1:0] mask_high_ff;
	logic [DW-1:0] nxt_mask_low;
	logic [DW-1:0] nxt_mask_high;
	wire  logic    reload_mask;

	assign reload_mask = nv_load | cmd_set_default;

	always_comb begin
		nxt_mask_low  = mask_low_ff;
		nxt_mask_high = mask_high_ff;
		if (reload_mask) begin
			nxt_mask_low  = nv_mask_defaults_low;
			nxt_mask_high = nv_mask_defaults_high;
		end
		if (wr_mask_low) begin
			nxt_mask_low = reg_req.wdata;
		end
		if (wr_mask_high) begin
			nxt_mask_high = reg_req.wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			mask_low_ff  <= `TIU_MASK_RST;
			mask_high_ff <= `TIU_MASK_RST;
		end else begin
			mask_low_ff  <= nxt_mask_low;
			mask_high_ff <= nxt_mask_high;
		end
	end

	// ----------------------------------------
	// interrupt line
	// ----------------------------------------
	// mask touches only this term, never the flag registers
	wire logic [DW-1:0] pend_low;
	wire logic [DW-1:0] pend_high;
	wire logic          nxt_irq;

	assign pend_low  = nxt_flags_low  & ~nxt_mask_low;
	assign pend_high = nxt_flags_high & ~nxt_mask_high;
	assign nxt_irq   = |{pend_low, pend_high};

	always_ff @(posedge mclk) begin
		if (rst) irq_ff <= 1'b0;
		else     irq_ff <= nxt_irq;
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	// flags returned are those held before the read, clear lands the same edge
	logic [DW-1:0] rd_mux;

	always_comb begin
		rd_mux = `TIU_RDATA_UNMAPPED;
		case (1'b1)
			hit_mask_low:   rd_mux = mask_low_ff;
			hit_mask_high:  rd_mux = mask_high_ff;
			hit_flags_low:  rd_mux = flags_low_ff;
			hit_flags_high: rd_mux = flags_high_ff;
			default:        rd_mux = `TIU_RDATA_UNMAPPED;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			reg_rsp_ff <= '0;
		end else begin
			reg_rsp_ff.valid <= reg_req.rd_en;
			reg_rsp_ff.rdata <= reg_req.rd_en ? rd_mux : reg_rsp_ff.rdata;
		end
	end

endmodule : tiu_interrupt_unit

// file: tiu_monitor.sv
// port checker of the tag interrupt unit
`timescale 1ns/100ps
module tiu_monitor (
	input wire logic                  mclk,
	input wire logic                  rst,
	input wire tiu_pkg::tiu_events_t  events,
	input wire logic                  cmd_set_default,
	input wire logic                  nv_load,
	input wire tiu_pkg::tiu_reg_req_t reg_req,
	input wire tiu_pkg::tiu_reg_rsp_t reg_rsp_ff,
	input wire logic                  irq_ff
);
	import tiu_pkg::*;
	wire logic rd_lo = reg_req.rd_en && reg_req.addr == 8'h0A;
	wire logic rd_hi = reg_req.rd_en && reg_req.addr == 8'h0B;
	wire logic ctl   = reg_req.wr_en || nv_load || cmd_set_default;
	wire logic quiet = events == '0 && !cmd_set_default;
	// power_up and set-default wipe the flags, so they break the chain
	wire logic keep  = !reg_req.rd_en && !cmd_set_default && !events.power_up;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	sequence s_quiet_read;
		rd_lo && quiet ##1 quiet ##1 rd_lo;
	endsequence
	sequence s_mask_write;
		reg_req.wr_en && reg_req.addr == 8'h08 ##1 !ctl ##1 reg_req.rd_en && reg_req.addr == 8'h08 && !ctl;
	endsequence
	read_answer_a: assert property (reg_req.rd_en |=> reg_rsp_ff.valid)
		else $error("read not answered");
	quiet_bus_a: assert property (!reg_req.rd_en |=> !reg_rsp_ff.valid)
		else $error("answer without read");
	exit_latch_a: assert property (events.field_exit ##1 keep ##1 rd_lo |=> reg_rsp_ff.rdata[0])
		else $error("field exit not latched");
	access_latch_a: assert property (events.access_err ##1 keep ##1 rd_hi |=> reg_rsp_ff.rdata[0])
		else $error("access fault not latched");
	read_clear_a: assert property (s_quiet_read |=> reg_rsp_ff.rdata == 8'h00)
		else $error("flags not cleared by read");
	mask_echo_a: assert property (s_mask_write |=> reg_rsp_ff.rdata == $past(reg_req.wdata, 3))
		else $error("mask readback differs");
	irq_rise_a: assert property ($rose(irq_ff) |-> $past(events != '0 || ctl))
		else $error("interrupt rose without cause");
	irq_fall_a: assert property ($fell(irq_ff) |-> $past(reg_req.rd_en || ctl || events.power_up))
		else $error("interrupt fell without cause");
endmodule : tiu_monitor

bind tiu_interrupt_unit tiu_monitor mon (.mclk(mclk), .rst(rst), .events(events),
	.cmd_set_default(cmd_set_default), .nv_load(nv_load), .reg_req(reg_req),
	.reg_rsp_ff(reg_rsp_ff), .irq_ff(irq_ff));

// file: tiu_pkg.sv
// types shared by the tag interrupt unit
package tiu_pkg;

	// ----------------------------------------
	// event sources, one-cycle pulses
	// ----------------------------------------
	typedef struct packed {
		logic power_up;
		logic field_on_powered;
		logic cmd_go_sleep;
		logic cmd_go_sense;
		logic cmd_sense_sleep;
		logic selected_wakeup_event;
		logic sleep_req;
		logic reader_write_event;
		logic reader_read_event;
		logic rx_end;
		logic tx_end;
		logic field_exit;
		logic rx_start;
		logic framing_err;
		logic parity_err;
		logic crc_err;
		logic buffer_fault_event;
		logic host_prog_done;
		logic prot_write_err;
		logic access_err;
	} tiu_events_t;

	// ----------------------------------------
	// register access port
	// ----------------------------------------
	typedef struct packed {
		logic       rd_en;
		logic       wr_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tiu_reg_req_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] rdata;
	} tiu_reg_rsp_t;

endpackage : tiu_pkg
